// >>> logic/typeb_card_anticollision_fsm.sv
// Type B card command decoder and anticollision state machine
`timescale 1ns/1ps
`default_nettype none
module typeb_card_anticollision_fsm #(
    parameter bit MULTISLOT_DEFAULT = 1'b1
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    // Received frame bytes, last one marks frame end
    input  wire logic                      rx_valid,
    input  wire logic [7:0]                rx_byte,
    input  wire logic                      rx_last,
    // Card identity and options
    input  wire logic [7:0]                card_afi,
    input  wire logic                      multislot_enable,
    // Reply request and state
    output logic                           atqb_send,
    output var typeb_pkg::card_state_type  expected_target_state
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        typeb_pkg::card_state_type st;
        logic [2:0]                count;
        logic [7:0]                first;
        logic [7:0]                afi;
        logic [7:0]                param;
        logic [15:0]               lfsr;
        logic [3:0]                slot;
        logic                      atqb;
    } fsm_state_type;

    fsm_state_type cur;
    fsm_state_type next_cur;
    logic          rst_meta;
    logic          rst_sync;
    logic          crc_good;

    // Reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    typeb_crc_check u_crc (
        .clk          (clk),
        .rst_n        (rst_sync),
        .ce           (ce),
        .byte_valid   (rx_valid),
        .byte_data    (rx_byte),
        .frame_end    (rx_last),
        .residue_good (crc_good)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic afi_match(input logic [7:0] req, input logic [7:0] own);
        return (req == 8'h00) || (req == own) ||
               ((req[3:0] == 4'h0) && (req[7:4] == own[7:4]));
    endfunction

    function automatic logic [3:0] slot_mask(input logic [2:0] code);
        logic [2:0] c;
        c = (code > typeb_pkg::N_CODE_MAX) ? typeb_pkg::N_CODE_MAX : code;
        return 4'((5'h01 << c) - 5'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic       frame_done;
    logic       frame_ok;
    logic [2:0] length;
    logic       is_req;
    logic       is_mark;
    logic       afi_ok;
    logic       multi;
    logic [3:0] mask;
    logic [3:0] pick;
    logic [3:0] mark_slot;

    always_comb begin
        frame_done = ce && rx_valid && rx_last;
        frame_ok   = frame_done && crc_good;
        length     = cur.count + 3'h1;
        is_req     = (length == typeb_pkg::REQ_LEN) && (cur.first == typeb_pkg::REQ_PREFIX);
        is_mark    = (length == typeb_pkg::MARK_LEN) && (cur.first[3:0] == typeb_pkg::MARK_NIBBLE)
                     && (cur.first[7:4] != 4'h0);
        mark_slot  = cur.first[7:4];
        afi_ok     = afi_match(cur.afi, card_afi);
        mask       = slot_mask(cur.param[typeb_pkg::PARAM_N_LSB +: typeb_pkg::PARAM_N_W]);
        multi      = multislot_enable && MULTISLOT_DEFAULT && (mask != 4'h0);
        pick       = cur.lfsr[3:0] & mask;
    end

    always_comb begin
        next_cur = cur;
        next_cur.atqb = 1'b0;
        next_cur.lfsr = cur.lfsr[0] ? ((cur.lfsr >> 1) ^ typeb_pkg::LFSR_TAPS) : (cur.lfsr >> 1);
        if (rx_valid) begin
            // Keep the first three bytes; later ones are the check or ignored
            case (cur.count)
                3'h0:    next_cur.first = rx_byte;
                3'h1:    next_cur.afi   = rx_byte;
                3'h2:    next_cur.param = rx_byte;
                default: next_cur.first = cur.first;
            endcase
            if (rx_last) begin
                next_cur.count = 3'h0;
            end else if (cur.count != 3'h7) begin
                next_cur.count = cur.count + 3'h1;
            end
        end
        // Halt, attrib, blocks and deselect decode to nothing here: silent, state kept
        if (frame_ok) begin
            case (cur.st)
                typeb_pkg::CARD_IDLE: begin
                    if (is_req && afi_ok) begin
                        if (!multi) begin
                            next_cur.atqb = 1'b1;
                            next_cur.st   = typeb_pkg::CARD_READY_DECLARED;
                        end else if (pick == 4'h0) begin
                            next_cur.atqb = 1'b1;
                            next_cur.st   = typeb_pkg::CARD_READY_DECLARED;
                        end else begin
                            next_cur.slot = pick;
                            next_cur.st   = typeb_pkg::CARD_READY_REQUESTED;
                        end
                    end
                    // Markers and unmatched AFI leave idle untouched
                end
                typeb_pkg::CARD_READY_REQUESTED: begin
                    if (is_req && !afi_ok) begin
                        next_cur.st = typeb_pkg::CARD_IDLE;
                    end else if (is_req && !multi) begin
                        next_cur.atqb = 1'b1;
                        next_cur.st   = typeb_pkg::CARD_READY_DECLARED;
                    end else if (is_mark && (mark_slot == cur.slot)) begin
                        next_cur.atqb = 1'b1;
                        next_cur.st   = typeb_pkg::CARD_READY_DECLARED;
                    end
                    // Multi-slot repeats keep the old slot and stay silent
                end
                default: begin
                    next_cur.st = cur.st;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            cur.st    <= typeb_pkg::CARD_IDLE;
            cur.count <= 3'h0;
            cur.first <= 8'h00;
            cur.afi   <= 8'h00;
            cur.param <= 8'h00;
            cur.lfsr  <= typeb_pkg::LFSR_SEED;
            cur.slot  <= 4'h0;
            cur.atqb  <= 1'b0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign atqb_send             = cur.atqb;
    assign expected_target_state = cur.st;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync);

    chk_idle_single_answer: assert property (
        (cur.st == typeb_pkg::CARD_IDLE) && frame_ok && is_req && afi_ok && !multi
        |=> atqb_send && (expected_target_state == typeb_pkg::CARD_READY_DECLARED))
        else $error("idle single-slot request not answered");

    chk_idle_stays_idle: assert property (
        (cur.st == typeb_pkg::CARD_IDLE) && ce && !(frame_ok && is_req && afi_ok)
        |=> !atqb_send && (expected_target_state == typeb_pkg::CARD_IDLE))
        else $error("idle card left idle or replied");

    chk_idle_marker_mute: assert property (
        (cur.st == typeb_pkg::CARD_IDLE) && frame_ok && is_mark
        |=> !atqb_send && (expected_target_state == typeb_pkg::CARD_IDLE))
        else $error("idle card reacted to slot marker");

    chk_multi_first_slot: assert property (
        (cur.st == typeb_pkg::CARD_IDLE) && frame_ok && is_req && afi_ok && multi
        |=> (atqb_send == ($past(pick) == 4'h0)) && (expected_target_state ==
            (($past(pick) == 4'h0) ? typeb_pkg::CARD_READY_DECLARED : typeb_pkg::CARD_READY_REQUESTED)))
        else $error("multi-slot request outcome wrong");

    chk_req_single_answer: assert property (
        (cur.st == typeb_pkg::CARD_READY_REQUESTED) && frame_ok && is_req && afi_ok && !multi
        |=> atqb_send && (expected_target_state == typeb_pkg::CARD_READY_DECLARED))
        else $error("requested single-slot request not answered");

    chk_marker_slot_match: assert property (
        (cur.st == typeb_pkg::CARD_READY_REQUESTED) && frame_ok && is_mark
        |=> atqb_send == ($past(mark_slot) == $past(cur.slot)))
        else $error("slot marker answer does not match chosen slot");

    chk_requested_multi_hold: assert property (
        (cur.st == typeb_pkg::CARD_READY_REQUESTED) && frame_ok && is_req && afi_ok && multi
        |=> !atqb_send && (expected_target_state == typeb_pkg::CARD_READY_REQUESTED) && $stable(cur.slot))
        else $error("requested card reacted to multi-slot request");

    chk_afi_back_idle: assert property (
        (cur.st == typeb_pkg::CARD_READY_REQUESTED) && frame_ok && is_req && !afi_ok
        |=> !atqb_send && (expected_target_state == typeb_pkg::CARD_IDLE))
        else $error("unmatched AFI did not return card to idle");

    chk_bad_check_drop: assert property (
        frame_done && !crc_good |=> !atqb_send && $stable(expected_target_state))
        else $error("frame with bad check changed state");

    chk_reply_one_cycle: assert property (
        atqb_send && ce |=> !atqb_send)
        else $error("reply request longer than one cycle");

    cov_idle_answer:   cover property ((cur.st == typeb_pkg::CARD_IDLE) ##1 atqb_send);
    cov_enter_request: cover property ((cur.st == typeb_pkg::CARD_IDLE) ##1
                                       (cur.st == typeb_pkg::CARD_READY_REQUESTED));
    cov_marker_answer: cover property ((cur.st == typeb_pkg::CARD_READY_REQUESTED) && frame_ok && is_mark
                                       ##1 atqb_send);
    cov_afi_drop:      cover property ((cur.st == typeb_pkg::CARD_READY_REQUESTED) ##1
                                       (cur.st == typeb_pkg::CARD_IDLE));
endmodule
`default_nettype wire

// >>> logic/typeb_crc_check.sv
// Running check-sequence residue over received frame bytes
`timescale 1ns/1ps
`default_nettype none
module typeb_crc_check (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Byte stream
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    input  wire logic       frame_end,
    // Result for the current byte
    output logic            residue_good
);
    typedef struct packed {
        logic [15:0] crc;
    } crc_state_type;

    crc_state_type cur;
    crc_state_type next_cur;
    logic [15:0]   crc_after;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ typeb_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_comb begin
        crc_after = crc_step(cur.crc, byte_data);
        residue_good = (crc_after == typeb_pkg::CRC_RESIDUE);
        next_cur = cur;
        if (byte_valid) begin
            // Preset again at the end so the next frame starts clean
            next_cur.crc = frame_end ? typeb_pkg::CRC_PRESET : crc_after;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur.crc <= typeb_pkg::CRC_PRESET;
        end else if (ce) begin
            cur <= next_cur;
        end
    end
endmodule
`default_nettype wire

// >>> logic/typeb_pkg.sv
// Constants and types shared by the Type B card command logic
package typeb_pkg;
    // Request frame: prefix byte, then AFI byte, then parameter byte
    localparam logic [7:0]  REQ_PREFIX     = 8'h05;
    localparam int          PARAM_WAKE_BIT = 3;
    localparam int          PARAM_N_LSB    = 0;
    localparam int          PARAM_N_W      = 3;
    // Slot marker: low nibble fixed, high nibble holds slot number minus one
    localparam logic [3:0]  MARK_NIBBLE    = 4'h5;
    // Frame lengths including the two check bytes
    localparam logic [2:0]  REQ_LEN        = 3'h5;
    localparam logic [2:0]  MARK_LEN       = 3'h3;
    // Check sequence: reflected polynomial, preset and good residue
    localparam logic [15:0] CRC_POLY       = 16'h8408;
    localparam logic [15:0] CRC_PRESET     = 16'hFFFF;
    localparam logic [15:0] CRC_RESIDUE    = 16'hF0B8;
    // Slot choice generator
    localparam logic [15:0] LFSR_SEED      = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS      = 16'hB400;
    localparam logic [2:0]  N_CODE_MAX     = 3'h4;

    typedef enum logic [1:0] {
        CARD_IDLE,
        CARD_READY_REQUESTED,
        CARD_READY_DECLARED
    } card_state_type;
endpackage

// >>> testbench/testbench.sv
// Self-checking bench for the Type B card anticollision state machine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Bench identities and command codes the card must ignore here
    localparam logic [7:0]  bench_afi            = 8'h3A;
    localparam logic [31:0] foreign_pupi         = 32'h5A5A_1234;
    localparam logic [7:0]  cmd_halt             = 8'h50;
    localparam logic [7:0]  cmd_attrib           = 8'h1D;
    localparam logic [15:0] probe_protocol_block = 16'h0200;
    localparam logic [7:0]  cmd_deselect         = 8'hC2;
    localparam int          cycle_limit          = 20000;

    logic                      clk = 1'b0;
    logic                      nrst;
    logic                      ce;
    logic                      rx_valid;
    logic [7:0]                rx_byte;
    logic                      rx_last;
    logic [7:0]                card_afi;
    logic                      multislot_enable;
    logic                      atqb_send;
    typeb_pkg::card_state_type expected_target_state;
    int                        errors          = 0;
    int                        samples_checked = 0;
    int                        cycles          = 0;

    always #4 clk = ~clk;

    typeb_card_anticollision_fsm dut_u (
        .clk                   (clk),
        .nrst                  (nrst),
        .ce                    (ce),
        .rx_valid              (rx_valid),
        .rx_byte               (rx_byte),
        .rx_last               (rx_last),
        .card_afi              (card_afi),
        .multislot_enable      (multislot_enable),
        .atqb_send             (atqb_send),
        .expected_target_state (expected_target_state)
    );

    typeb_reader_model reader_u (
        .clk       (clk),
        .rx_valid  (rx_valid),
        .rx_byte   (rx_byte),
        .rx_last   (rx_last),
        .atqb_send (atqb_send)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == cycle_limit) begin
            errors++;
            final_report();
        end
    end

    task automatic check_reply(input logic got, input logic want);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("wrong value at %0t: reply got %0h expected %0h", $time, got, want);
        end
    endtask

    task automatic check_state(input typeb_pkg::card_state_type got, input typeb_pkg::card_state_type want);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("wrong value at %0t: state got %0h expected %0h", $time, got, want);
        end
    endtask

    task automatic check_count(input int got, input int want);
        samples_checked++;
        if (got != want) begin
            errors++;
            $display("wrong value at %0t: answers got %0h expected %0h", $time, got, want);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Power cycle: the only way back to idle once the card has declared itself
    task automatic power_up(input int settle);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2 + settle) @(posedge clk);
    endtask

    task automatic expect_result(input logic reply, input logic want_reply,
                                 input typeb_pkg::card_state_type want_state);
        check_reply(reply, want_reply);
        check_state(expected_target_state, want_state);
    endtask

    task automatic req(input logic [7:0] afi, input logic [2:0] code, input bit wake, input bit bad,
                       output logic reply);
        logic [7:0] param;
        param = 8'h00;
        param[typeb_pkg::PARAM_WAKE_BIT] = wake;
        param[typeb_pkg::PARAM_N_LSB +: typeb_pkg::PARAM_N_W] = code;
        reader_u.send_frame({48'h0, typeb_pkg::REQ_PREFIX, afi, param}, 3, bad, reply);
    endtask

    // Every marker 2 to 16; after an answer the card must have declared itself
    task automatic sweep_markers(input typeb_pkg::card_state_type st, input int want_hits);
        logic reply;
        int   hits;
        hits = 0;
        for (int n = 2; n <= 16; n++) begin
            reader_u.send_frame({64'h0, 4'(n - 1), typeb_pkg::MARK_NIBBLE}, 1, 1'b0, reply);
            if (reply === 1'b1) begin
                hits++;
            end
            check_state(expected_target_state, (hits > 0) ? typeb_pkg::CARD_READY_DECLARED : st);
        end
        check_count(hits, want_hits);
    endtask

    task automatic send_ignored(input typeb_pkg::card_state_type st);
        logic        reply;
        logic [31:0] pupi;
        for (int wake = 0; wake < 2; wake++) begin
            req(8'h00, 3'h0, wake[0], 1'b1, reply);
            expect_result(reply, 1'b0, st);
        end
        for (int p = 0; p < 2; p++) begin
            pupi = (p == 0) ? 32'h0000_0000 : foreign_pupi;
            reader_u.send_frame({32'h0, cmd_halt, pupi}, 5, 1'b0, reply);
            expect_result(reply, 1'b0, st);
            reader_u.send_frame({cmd_attrib, pupi, 32'h0008_0100}, 9, 1'b0, reply);
            expect_result(reply, 1'b0, st);
        end
        reader_u.send_frame({56'h0, probe_protocol_block}, 2, 1'b0, reply);
        expect_result(reply, 1'b0, st);
        reader_u.send_frame({64'h0, cmd_deselect}, 1, 1'b0, reply);
        expect_result(reply, 1'b0, st);
    endtask

    // An immediate answer declares the card, so power cycle and retry later
    task automatic enter_requested(input bit wake);
        logic reply;
        reply = 1'b1;
        for (int attempt = 0; attempt < 8 && reply; attempt++) begin
            power_up(attempt);
            req(8'h00, typeb_pkg::N_CODE_MAX, wake, 1'b0, reply);
            if (reply) begin
                check_state(expected_target_state, typeb_pkg::CARD_READY_DECLARED);
            end
        end
        expect_result(reply, 1'b0, typeb_pkg::CARD_READY_REQUESTED);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic idle_single();
        logic       reply;
        logic [7:0] afi;
        for (int v = 0; v < 3; v++) begin
            afi = (v == 0) ? 8'h00 : (v == 1) ? bench_afi : {bench_afi[7:4], 4'h0};
            power_up(0);
            req(afi, 3'h0, v[0], 1'b0, reply);
            expect_result(reply, 1'b1, typeb_pkg::CARD_READY_DECLARED);
        end
    endtask

    task automatic idle_mute();
        logic reply;
        power_up(0);
        send_ignored(typeb_pkg::CARD_IDLE);
        for (int wake = 0; wake < 2; wake++) begin
            req(~bench_afi, 3'h0, wake[0], 1'b0, reply);
            expect_result(reply, 1'b0, typeb_pkg::CARD_IDLE);
        end
        sweep_markers(typeb_pkg::CARD_IDLE, 0);
        req(8'h00, 3'h0, 1'b0, 1'b0, reply);
        expect_result(reply, 1'b1, typeb_pkg::CARD_READY_DECLARED);
    endtask

    task automatic requested_single();
        logic reply;
        for (int wake = 0; wake < 2; wake++) begin
            enter_requested(wake[0]);
            req(8'h00, 3'h0, wake[0], 1'b0, reply);
            expect_result(reply, 1'b1, typeb_pkg::CARD_READY_DECLARED);
        end
    endtask

    task automatic requested_mute();
        logic reply;
        enter_requested(1'b0);
        send_ignored(typeb_pkg::CARD_READY_REQUESTED);
        for (int wake = 0; wake < 2; wake++) begin
            req(8'h00, typeb_pkg::N_CODE_MAX, wake[0], 1'b0, reply);
            expect_result(reply, 1'b0, typeb_pkg::CARD_READY_REQUESTED);
        end
        sweep_markers(typeb_pkg::CARD_READY_REQUESTED, 1);
    endtask

    task automatic requested_afi();
        logic reply;
        for (int wake = 0; wake < 2; wake++) begin
            enter_requested(wake[0]);
            req(~bench_afi, 3'h0, wake[0], 1'b0, reply);
            expect_result(reply, 1'b0, typeb_pkg::CARD_IDLE);
            sweep_markers(typeb_pkg::CARD_IDLE, 0);
        end
    endtask

    task automatic no_multislot();
        logic reply;
        @(posedge clk);
        multislot_enable <= 1'b0;
        power_up(0);
        sweep_markers(typeb_pkg::CARD_IDLE, 0);
        req(8'h00, typeb_pkg::N_CODE_MAX, 1'b0, 1'b0, reply);
        expect_result(reply, 1'b1, typeb_pkg::CARD_READY_DECLARED);
        @(posedge clk);
        multislot_enable <= 1'b1;
    endtask

    // A frame sent while the enable is low must leave no trace
    task automatic clock_frozen();
        logic reply;
        power_up(0);
        @(posedge clk);
        ce <= 1'b0;
        req(8'h00, 3'h0, 1'b0, 1'b0, reply);
        expect_result(reply, 1'b0, typeb_pkg::CARD_IDLE);
        @(posedge clk);
        ce <= 1'b1;
        req(8'h00, 3'h0, 1'b0, 1'b0, reply);
        expect_result(reply, 1'b1, typeb_pkg::CARD_READY_DECLARED);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst             = 1'b0;
        ce               = 1'b1;
        card_afi         = bench_afi;
        multislot_enable = 1'b1;
        idle_single();
        idle_mute();
        requested_single();
        requested_mute();
        requested_afi();
        no_multislot();
        clock_frozen();
        final_report();
    end
endmodule
`default_nettype wire

// >>> testbench/typeb_reader_model.sv
// Test reader model that frames commands with check bytes and watches for the answer
`timescale 1ns/1ps
`default_nettype none
module typeb_reader_model (
    // Clock
    input  wire logic       clk,
    // Frame bytes towards the card
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_last,
    // Answer from the card
    input  wire logic       atqb_send
);
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
        rx_last  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One command, one reply: the card is judged in the cycle after the last byte
    // Body bytes sit right-aligned in the packed word, first byte highest
    task automatic send_frame(input logic [71:0] body, input int len, input bit bad, output logic reply);
        logic [15:0] crc;
        logic [7:0]  frame [0:10];
        crc = typeb_pkg::CRC_PRESET;
        for (int i = 0; i < len; i++) begin
            frame[i] = body[8 * (len - 1 - i) +: 8];
            crc = crc ^ {8'h00, frame[i]};
            for (int k = 0; k < 8; k++) begin
                crc = crc[0] ? ((crc >> 1) ^ typeb_pkg::CRC_POLY) : (crc >> 1);
            end
        end
        // Uncomplemented check bytes give the corrupted frame
        if (!bad) begin
            crc = ~crc;
        end
        frame[len]     = crc[7:0];
        frame[len + 1] = crc[15:8];
        for (int i = 0; i < len + 2; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte  <= frame[i];
            rx_last  <= (i == len + 1);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        // Released byte lines must not keep showing the last value
        rx_byte  <= ~frame[len + 1];
        @(negedge clk);
        reply = atqb_send;
    endtask
endmodule
`default_nettype wire
